// >>> hdl/tpl_pkg.sv
// constants shared by the probe position latch block
// assumes one 100 MHz control clock and the object index port of the drive

package tpl_pkg;

	// ==========================================================
	// object indices
	localparam logic [15:0] TPL_IDX_CTRL   = 16'h60B8;
	localparam logic [15:0] TPL_IDX_STATE  = 16'h60B9;
	localparam logic [15:0] TPL_IDX_A_RISE = 16'h60BA;
	localparam logic [15:0] TPL_IDX_A_FALL = 16'h60BB;
	localparam logic [15:0] TPL_IDX_B_RISE = 16'h60BC;
	localparam logic [15:0] TPL_IDX_B_FALL = 16'h60BD;

	// ==========================================================
	// field positions inside one probe byte
	localparam int TPL_CH_BITS   = 8;
	localparam int TPL_CF_EN     = 0;
	localparam int TPL_CF_CONT   = 1;
	localparam int TPL_CF_SRC    = 2;
	localparam int TPL_CF_RISE   = 4;
	localparam int TPL_CF_FALL   = 5;
	localparam int TPL_SF_EN     = 0;
	localparam int TPL_SF_RISE   = 1;
	localparam int TPL_SF_FALL   = 2;
	localparam int TPL_SF_CNT_LO = 6;

	// ==========================================================
	// reset values, pin and channel counts
	localparam logic [15:0] TPL_CTRL_RST = 16'h0000;
	localparam logic [31:0] TPL_POS_RST  = 32'h0000_0000;
	localparam logic [1:0]  TPL_CNT_RST  = 2'h0;
	localparam int          TPL_PINS     = 4;
	localparam int          TPL_N_CH     = 2;

endpackage : tpl_pkg

// >>> hdl/tpl_channel.sv
// one probe channel: edge detection, capture, status byte
// assumes trigger levels already synchronised to ref_clk
`timescale 1ns/10ps

module tpl_channel
	import tpl_pkg::*;
#(
	parameter int POS_W = 32
) (
	// clock, reset, enable
	input  wire logic             ref_clk,
	input  wire logic             rst_b,
	input  wire logic             ce,
	// control byte and triggers
	input  wire logic [7:0]       ctrl,
	input  wire logic             ext_lvl,
	input  wire logic             idx_lvl,
	input  wire logic [POS_W-1:0] position,
	// results
	output logic      [7:0]       status,
	output logic      [POS_W-1:0] rise_pos,
	output logic      [POS_W-1:0] fall_pos,
	output logic                  capture
);

	// ==========================================================
	// trigger selection and edge detection
	logic             en, cont, lvl, rise_ev, fall_ev;
	logic             en_q, en_d, trig_q, trig_d;
	logic             rdone_q, rdone_d, fdone_q, fdone_d;
	logic [1:0]       cnt_q, cnt_d;
	logic [POS_W-1:0] rpos_q, rpos_d, fpos_q, fpos_d;

	assign en   = ctrl[TPL_CF_EN];
	assign cont = ctrl[TPL_CF_CONT];
	assign lvl  = ctrl[TPL_CF_SRC] ? idx_lvl : ext_lvl;

	// single shot gating; a source switch can look like an edge
	assign rise_ev = en && ctrl[TPL_CF_RISE] && lvl && !trig_q && (cont || !rdone_q);
	assign fall_ev = en && ctrl[TPL_CF_FALL] && !lvl && trig_q && (cont || !fdone_q);

	// next state: clear on disable or arming, then set wins
	always_comb begin
		trig_d  = lvl;
		en_d    = en;
		rdone_d = rdone_q;
		fdone_d = fdone_q;
		cnt_d   = cnt_q;
		rpos_d  = rpos_q;
		fpos_d  = fpos_q;
		if (!en || !en_q) begin
			rdone_d = 1'b0;
			fdone_d = 1'b0;
			cnt_d   = TPL_CNT_RST;
		end
		if (rise_ev) begin
			rpos_d  = position;
			rdone_d = 1'b1;
		end
		if (fall_ev) begin
			fpos_d  = position;
			fdone_d = 1'b1;
		end
		if (cont && (rise_ev || fall_ev))
			cnt_d = cnt_q + 2'h1;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			trig_q  <= 1'b0;
			en_q    <= 1'b0;
			rdone_q <= 1'b0;
			fdone_q <= 1'b0;
			cnt_q   <= TPL_CNT_RST;
			rpos_q  <= POS_W'(TPL_POS_RST);
			fpos_q  <= POS_W'(TPL_POS_RST);
		end else if (ce) begin
			trig_q  <= trig_d;
			en_q    <= en_d;
			rdone_q <= rdone_d;
			fdone_q <= fdone_d;
			cnt_q   <= cnt_d;
			rpos_q  <= rpos_d;
			fpos_q  <= fpos_d;
		end
	end

	assign status   = {cnt_q, 3'h0, fdone_q, rdone_q, en_q};
	assign rise_pos = rpos_q;
	assign fall_pos = fpos_q;
	assign capture  = ce && (rise_ev || fall_ev);

	// ==========================================================
	// checks
	property p_rise_capture;
		@(posedge ref_clk) disable iff (!rst_b)
		(ce && rise_ev) |=> (rpos_q == $past(position)) && rdone_q;
	endproperty
	a_rise_capture: assert property (p_rise_capture) else $error("rise capture missed");

	property p_rise_off;
		@(posedge ref_clk) disable iff (!rst_b)
		!ctrl[TPL_CF_RISE] |=> $stable(rpos_q);
	endproperty
	a_rise_off: assert property (p_rise_off) else $error("rise capture while off");

	property p_fall_off;
		@(posedge ref_clk) disable iff (!rst_b)
		!ctrl[TPL_CF_FALL] |=> $stable(fpos_q);
	endproperty
	a_fall_off: assert property (p_fall_off) else $error("fall capture while off");

	property p_single;
		@(posedge ref_clk) disable iff (!rst_b)
		(en && en_q && !cont && rdone_q) |=> $stable(rpos_q);
	endproperty
	a_single: assert property (p_single) else $error("single shot recaptured");

	property p_fall_done;
		@(posedge ref_clk) disable iff (!rst_b)
		(ce && fall_ev) |=> fdone_q && (fpos_q == $past(position));
	endproperty
	a_fall_done: assert property (p_fall_done) else $error("fall flag or position not set");

	property p_count;
		@(posedge ref_clk) disable iff (!rst_b)
		(ce && en && en_q && cont && rise_ev) |=> cnt_q == $past(cnt_q) + 2'h1;
	endproperty
	a_count: assert property (p_count) else $error("execution count wrong");

	property p_disable;
		@(posedge ref_clk) disable iff (!rst_b)
		(ce && !en) |=> status == 8'h00;
	endproperty
	a_disable: assert property (p_disable) else $error("disabled probe not cleared");

	c_count_wrap: cover property (@(posedge ref_clk) cnt_q == 2'h3 ##[1:50] cnt_q == 2'h0);
	c_fall_capture: cover property (@(posedge ref_clk) ce && fall_ev);

endmodule : tpl_channel

// >>> hdl/tpl_top.sv
// probe position latch: pin sampling, object access, two channels
// assumes motor_position is on ref_clk; probe and encoder pins are not
// assumes the object port is driven by ref_clk logic of the fieldbus side
`timescale 1ns/10ps

module tpl_top #(
	parameter int POS_W = 32
) (
	// clock, reset, enable
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	input  wire logic        ce,
	// probe and encoder pins
	input  wire logic        probe_a_input,
	input  wire logic        probe_b_input,
	input  wire logic        encoder_external_input,
	input  wire logic        encoder_index,
	// feedback position
	input  wire logic [31:0] motor_position,
	// object access port
	input  wire logic [15:0] obj_index,
	input  wire logic        obj_wr,
	input  wire logic [31:0] obj_wdata,
	input  wire logic        obj_rd,
	output logic      [31:0] obj_rdata,
	output logic             obj_rvalid,
	output logic             obj_err,
	// capture strobes
	output logic      [1:0]  capture
);
	import tpl_pkg::*;

	// ==========================================================
	// elaboration check
	generate
		if (POS_W != 32) begin : g_bad_width
			$error("tpl_top: position objects are 32 bits wide");
		end
	endgenerate

	// ==========================================================
	// pin synchronisers
	logic [TPL_PINS-1:0] pins;
	logic [TPL_PINS-1:0] sync1_q, sync1_d;
	logic [TPL_PINS-1:0] sync2_q, sync2_d;

	assign pins = {encoder_index, encoder_external_input, probe_b_input, probe_a_input};

	// two stages before any logic looks at a pin
	always_comb begin
		sync1_d = pins;
		sync2_d = sync1_q;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else if (ce) begin
			sync1_q <= sync1_d;
			sync2_q <= sync2_d;
		end
	end

	// ==========================================================
	// trigger routing
	logic [TPL_N_CH-1:0] ext_lvl;
	logic                idx_lvl;

	// probe A pin, encoder external input shares its route
	assign ext_lvl[0] = sync2_q[0] | sync2_q[2];
	// probe B has its own pin
	assign ext_lvl[1] = sync2_q[1];
	assign idx_lvl    = sync2_q[3];

	// ==========================================================
	// control word
	logic [15:0] ctrl_q, ctrl_d;
	logic        wr_ctrl;

	assign wr_ctrl = obj_wr && (obj_index == TPL_IDX_CTRL);

	// reserved bits are stored as written, the host keeps them zero
	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_ctrl)
			ctrl_d = obj_wdata[15:0];
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b)
			ctrl_q <= TPL_CTRL_RST;
		else if (ce)
			ctrl_q <= ctrl_d;
	end

	// ==========================================================
	// probe channels
	logic [15:0]      status;
	logic [POS_W-1:0] rise_pos [TPL_N_CH];
	logic [POS_W-1:0] fall_pos [TPL_N_CH];

	// probe B takes the upper control byte
	generate
		for (genvar ch = 0; ch < TPL_N_CH; ch++) begin : g_ch
			tpl_channel #(
				.POS_W (POS_W)
			) u_ch (
				.ref_clk  (ref_clk),
				.rst_b    (rst_b),
				.ce       (ce),
				.ctrl     (ctrl_q[ch*TPL_CH_BITS +: TPL_CH_BITS]),
				.ext_lvl  (ext_lvl[ch]),
				.idx_lvl  (idx_lvl),
				.position (motor_position[POS_W-1:0]),
				.status   (status[ch*TPL_CH_BITS +: TPL_CH_BITS]),
				.rise_pos (rise_pos[ch]),
				.fall_pos (fall_pos[ch]),
				.capture  (capture[ch])
			);
		end
	endgenerate

	// ==========================================================
	// object read path
	logic [31:0] rdata_q, rdata_d;
	logic        rvalid_q, rvalid_d;
	logic        err_q, err_d;
	logic [31:0] rd_mux;
	logic        rd_hit;

	// status word in the low half
	// probe A results at their own objects
	always_comb begin
		rd_hit = 1'b1;
		unique case (obj_index)
			TPL_IDX_CTRL:   rd_mux = {16'h0000, ctrl_q};
			TPL_IDX_STATE:  rd_mux = {16'h0000, status};
			TPL_IDX_A_RISE: rd_mux = rise_pos[0];
			TPL_IDX_A_FALL: rd_mux = fall_pos[0];
			TPL_IDX_B_RISE: rd_mux = rise_pos[1];
			TPL_IDX_B_FALL: rd_mux = fall_pos[1];
			default: begin
				rd_mux = 32'h0000_0000;
				rd_hit = 1'b0;
			end
		endcase
	end

	// unknown index or a write to a read-only object flags an error;
	// the read answer comes on the next ce cycle after a request taken while ce is high
	always_comb begin
		rvalid_d = obj_rd;
		rdata_d  = rdata_q;
		err_d    = 1'b0;
		if (obj_rd) begin
			rdata_d = rd_mux;
			err_d   = !rd_hit;
		end
		if (obj_wr && !wr_ctrl)
			err_d = 1'b1;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			rdata_q  <= 32'h0000_0000;
			rvalid_q <= 1'b0;
			err_q    <= 1'b0;
		end else if (ce) begin
			rdata_q  <= rdata_d;
			rvalid_q <= rvalid_d;
			err_q    <= err_d;
		end
	end

	assign obj_rdata  = rdata_q;
	assign obj_rvalid = rvalid_q && ce;
	assign obj_err    = err_q && ce;

	// ==========================================================
	// checks
	property p_ctrl_write;
		@(posedge ref_clk) disable iff (!rst_b)
		(ce && wr_ctrl) |=> ctrl_q == $past(obj_wdata[15:0]);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

	property p_ctrl_reset;
		@(posedge ref_clk)
		!rst_b |=> ctrl_q == 16'h0000;
	endproperty
	a_ctrl_reset: assert property (p_ctrl_reset) else $error("control not reset to zero");

	property p_b_enable;
		@(posedge ref_clk) disable iff (!rst_b)
		(ce && ctrl_q[8]) |=> status[8];
	endproperty
	a_b_enable: assert property (p_b_enable) else $error("probe B enable not shown");

	property p_state_read;
		@(posedge ref_clk) disable iff (!rst_b)
		(ce && obj_rd && obj_index == TPL_IDX_STATE) |=>
			obj_rdata == {16'h0000, $past(status)};
	endproperty
	a_state_read: assert property (p_state_read) else $error("status read wrong");

	property p_a_rise_read;
		@(posedge ref_clk) disable iff (!rst_b)
		(ce && obj_rd && obj_index == TPL_IDX_A_RISE) |=>
			obj_rdata == $past(rise_pos[0]);
	endproperty
	a_a_rise_read: assert property (p_a_rise_read) else $error("probe A rise read wrong");

	property p_b_mode;
		@(posedge ref_clk) disable iff (!rst_b)
		(ce && ctrl_q[8] && !ctrl_q[9] && status[9]) |=> $stable(rise_pos[1]);
	endproperty
	a_b_mode: assert property (p_b_mode) else $error("probe B single shot recaptured");

	property p_pin_delay;
		@(posedge ref_clk) disable iff (!rst_b)
		(ce ##1 ce ##1 ce) |-> sync2_q[0] == $past(probe_a_input, 2);
	endproperty
	a_pin_delay: assert property (p_pin_delay) else $error("probe A pin path wrong");

	property p_rd_answer;
		@(posedge ref_clk) disable iff (!rst_b)
		(ce && obj_rd) ##1 ce |-> obj_rvalid;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read not answered");

	c_both_capture: cover property (@(posedge ref_clk) capture == 2'h3);
	c_index_capture: cover property (@(posedge ref_clk) ctrl_q[2] && capture[0]);
	c_unmapped: cover property (@(posedge ref_clk) obj_err);

endmodule : tpl_top

// >>> dv/tpl_far_model.sv
// far side model: probe and encoder pins plus the feedback position source
// assumes the bench requests pin levels and positions on ref_clk edges
`timescale 1ns/10ps

module tpl_far_model (
	// clock
	input  wire logic        ref_clk,
	// requests from the host side of the bench
	input  wire logic [3:0]  pin_set,
	input  wire logic [31:0] pos_set,
	// pins and position towards the latch
	output logic      [3:0]  pins,
	output logic      [31:0] motor_position
);
	// ==========================================================
	// pins move off the clock
	// pins change 3 ns late so they land between edges like real wiring
	initial pins = 4'h0;
	always @(pin_set) begin
		pins <= #3 pin_set;
	end

	// position follows the request one edge later, held while pins move
	initial motor_position = 32'h0000_0000;
	// plain always: the initial value above is a second writer of this variable
	always @(posedge ref_clk) begin
		motor_position <= pos_set;
	end
endmodule : tpl_far_model

// >>> dv/touch_probe_position_latch_tb_top.sv
// self-checking bench for the probe position latch top
// assumes the far side model drives pins and position; bench is the host
`timescale 1ns/10ps

module touch_probe_position_latch_tb_top;
	import tpl_pkg::*;

	// ==========================================================
	// signals
	logic        ref_clk;
	logic        rst_b;
	logic [3:0]  pin_set;
	logic [31:0] pos_set;
	logic [3:0]  pins;
	logic [31:0] motor_position;
	logic [15:0] obj_index;
	logic        obj_wr;
	logic [31:0] obj_wdata;
	logic        obj_rd;
	logic [31:0] obj_rdata;
	logic        obj_rvalid;
	logic        obj_err;
	logic [1:0]  capture;
	logic [32:0] exp_q[$];
	logic [32:0] note;
	logic [31:0] pa, pb, pc, q1, q2;
	int          error_cnt;
	int          check_count;
	int          cap_a;
	int          cap_b;

	// ==========================================================
	// clock and instances
	initial ref_clk = 1'b0;
	always #5 ref_clk = ~ref_clk;

	tpl_far_model far (
		.ref_clk        (ref_clk),
		.pin_set        (pin_set),
		.pos_set        (pos_set),
		.pins           (pins),
		.motor_position (motor_position)
	);

	// ce tied high: clock gating is not part of the documented behaviour
	tpl_top dut (
		.ref_clk                (ref_clk),
		.rst_b                  (rst_b),
		.ce                     (1'b1),
		.probe_a_input          (pins[0]),
		.probe_b_input          (pins[1]),
		.encoder_external_input (pins[2]),
		.encoder_index          (pins[3]),
		.motor_position         (motor_position),
		.obj_index              (obj_index),
		.obj_wr                 (obj_wr),
		.obj_wdata              (obj_wdata),
		.obj_rd                 (obj_rd),
		.obj_rdata              (obj_rdata),
		.obj_rvalid             (obj_rvalid),
		.obj_err                (obj_err),
		.capture                (capture)
	);

	// ==========================================================
	// comparison, closing and watchdog
	task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wrap_up();
		if (error_cnt == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : wrap_up

	// oldest note against each read answer; answers hold one cycle only
	always @(posedge ref_clk) begin
		if (obj_rvalid === 1'b1) begin
			note = (exp_q.size() > 0) ? exp_q.pop_front() : 33'h1_DEAD_BEEF;
			chk("read answer", note, {obj_err, obj_rdata});
		end
	end

	// capture strobes stand one cycle; count every high cycle per probe
	always @(posedge ref_clk) begin
		if (capture[0] === 1'b1)
			cap_a++;
		if (capture[1] === 1'b1)
			cap_b++;
	end

	initial begin
		repeat (4000) @(posedge ref_clk);
		error_cnt++;
		wrap_up();
	end

	// ==========================================================
	// host and pin tasks
	task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic e);
		@(posedge ref_clk);
		obj_index <= idx;
		obj_wdata <= d;
		obj_wr    <= 1'b1;
		@(posedge ref_clk);
		obj_wr    <= 1'b0;
		#1;
		chk("write error flag", {32'h0, e}, {32'h0, obj_err});
	endtask : wr

	task automatic rd(input logic [15:0] idx, input logic [31:0] d, input logic e);
		@(posedge ref_clk);
		obj_index <= idx;
		obj_rd    <= 1'b1;
		exp_q.push_back({e, d});
		@(posedge ref_clk);
		obj_rd    <= 1'b0;
	endtask : rd

	// disarm first so each scenario starts from a fresh arming
	task automatic arm(input logic [15:0] c);
		wr(TPL_IDX_CTRL, 32'h0, 1'b0);
		wr(TPL_IDX_CTRL, {16'h0, c}, 1'b0);
	endtask : arm

	task automatic pin_edge(input logic [3:0] m, input logic lvl, input logic [31:0] p);
		@(posedge ref_clk);
		pos_set <= p;
		@(posedge ref_clk);
		pin_set <= lvl ? (pin_set | m) : (pin_set & ~m);
		repeat (6) @(posedge ref_clk);
	endtask : pin_edge

	// ==========================================================
	// main sequence
	initial begin
		error_cnt   = 0;
		check_count = 0;
		cap_a       = 0;
		cap_b       = 0;
		rst_b     = 1'b0;
		pin_set   = 4'h0;
		pos_set   = 32'h0;
		obj_index = 16'h0;
		obj_wr    = 1'b0;
		obj_wdata = 32'h0;
		obj_rd    = 1'b0;
		void'($urandom(44631));
		{pa, pb, pc, q1, q2} = {$urandom, $urandom, $urandom, $urandom, $urandom};
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		// reset values, unmapped index, writes to read-only objects
		for (int i = 0; i < 6; i++) begin
			rd(TPL_IDX_CTRL + 16'(i), 32'h0, 1'b0);
		end
		rd(16'h60BE, 32'h0, 1'b1);
		wr(TPL_IDX_STATE, 32'hFFFF, 1'b1);
		wr(TPL_IDX_A_RISE, 32'h1234_5678, 1'b1);
		rd(TPL_IDX_A_RISE, 32'h0, 1'b0);
		wr(TPL_IDX_CTRL, 32'h0000_FFFF, 1'b0);
		rd(TPL_IDX_CTRL, 32'h0000_FFFF, 1'b0);
		// probe A single shot, both edges, external pin
		arm(16'h0031);
		pin_edge(4'h1, 1'b1, pa);
		pin_edge(4'h1, 1'b0, pb);
		pin_edge(4'h1, 1'b1, pc);
		pin_edge(4'h1, 1'b0, pc);
		rd(TPL_IDX_A_RISE, pa, 1'b0);
		rd(TPL_IDX_A_FALL, pb, 1'b0);
		rd(TPL_IDX_STATE, 32'h0007, 1'b0);
		// probe A continuous on index pulse, rise only, five events
		arm(16'h0017);
		for (int k = 0; k < 5; k++) begin
			pc = $urandom;
			pin_edge(4'h8, 1'b1, pc);
			pin_edge(4'h8, 1'b0, ~pc);
		end
		rd(TPL_IDX_A_RISE, pc, 1'b0);
		rd(TPL_IDX_A_FALL, pb, 1'b0);
		rd(TPL_IDX_STATE, 32'h0043, 1'b0);
		// both probes together: A single, B continuous
		arm(16'h3331);
		pin_edge(4'h3, 1'b1, q1);
		pin_edge(4'h3, 1'b0, q2);
		rd(TPL_IDX_B_RISE, q1, 1'b0);
		rd(TPL_IDX_B_FALL, q2, 1'b0);
		rd(TPL_IDX_A_RISE, q1, 1'b0);
		rd(TPL_IDX_STATE, 32'h8707, 1'b0);
		// disable clears flags and stops captures
		wr(TPL_IDX_CTRL, 32'h0, 1'b0);
		rd(TPL_IDX_STATE, 32'h0, 1'b0);
		pin_edge(4'h3, 1'b1, pa);
		pin_edge(4'h3, 1'b0, pa);
		rd(TPL_IDX_A_RISE, q1, 1'b0);
		rd(TPL_IDX_B_FALL, q2, 1'b0);
		// encoder external input, probe B index source
		arm(16'h1713);
		pin_edge(4'hC, 1'b1, pa);
		pin_edge(4'hC, 1'b0, pb);
		rd(TPL_IDX_A_RISE, pa, 1'b0);
		rd(TPL_IDX_B_RISE, pa, 1'b0);
		rd(TPL_IDX_STATE, 32'h4343, 1'b0);
		// edge enables off: no capture
		arm(16'h0101);
		pin_edge(4'h3, 1'b1, pc);
		pin_edge(4'h3, 1'b0, pc);
		rd(TPL_IDX_A_FALL, q2, 1'b0);
		rd(TPL_IDX_B_RISE, pa, 1'b0);
		rd(TPL_IDX_STATE, 32'h0101, 1'b0);
		repeat (3) @(posedge ref_clk);
		chk("notes left", 33'h0, 33'(exp_q.size()));
		chk("probe A captures", 33'd10, 33'(cap_a));
		chk("probe B captures", 33'd3, 33'(cap_b));
		wrap_up();
	end
endmodule : touch_probe_position_latch_tb_top
